// ---- hdl/th_pkg.sv ----
// Shared constants and types for the interval / PWM timer
package th_pkg;
	// Register addresses on the CPU data port
	localparam logic [15:0] ADDR_PERIOD  = 16'hff1a;
	localparam logic [15:0] ADDR_DUTY    = 16'hff1b;
	localparam logic [15:0] ADDR_PORT3DIR = 16'hff23;
	localparam logic [15:0] ADDR_MODE    = 16'hff6c;
	localparam logic [15:0] ADDR_CARRIER = 16'hff71;
	localparam logic [15:0] ADDR_PORT3LAT = 16'hff03;

	// Reset values
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_PORT3DIR = 8'hff;

	// Fixed and writable bit masks
	localparam logic [7:0] PORT3DIR_FIXED = 8'he0;
	localparam logic [7:0] CARRIER_WMASK  = 8'h06;

	// Mode control field positions
	localparam int RUN_BIT   = 7;
	localparam int CKS_HI    = 6;
	localparam int CKS_LO    = 4;
	localparam int MODE_HI   = 3;
	localparam int MODE_LO   = 2;
	localparam int LEVEL_BIT = 1;
	localparam int OUTEN_BIT = 0;

	// Mode field codes
	localparam logic [1:0] MODE_INTERVAL = 2'b00;
	localparam logic [1:0] MODE_CARRIER  = 2'b01;
	localparam logic [1:0] MODE_PWM      = 2'b10;

	// Count clock select codes and divider widths (divide by 2**bits)
	localparam logic [2:0] CKS_DIV1    = 3'h0;
	localparam logic [2:0] CKS_DIV4    = 3'h1;
	localparam logic [2:0] CKS_DIV16   = 3'h2;
	localparam logic [2:0] CKS_DIV64   = 3'h3;
	localparam logic [2:0] CKS_DIV4096 = 3'h4;
	localparam logic [2:0] CKS_LS128   = 3'h5;
	localparam logic [2:0] CKS_LS512   = 3'h6;
	localparam int BITS_DIV4    = 2;
	localparam int BITS_DIV16   = 4;
	localparam int BITS_DIV64   = 6;
	localparam int BITS_DIV4096 = 12;
	localparam int BITS_LS128   = 7;
	localparam int BITS_LS512   = 9;

	// Count clocks a pending duty value must age before transfer
	localparam logic [1:0] DUTY_AGE_MIN = 2'h3;

	// Timer phase, Gray coded along stop, mask, period, duty
	typedef enum logic [1:0] {
		PH_STOP = 2'b00,
		PH_MASK = 2'b01,
		PH_PER  = 2'b11,
		PH_DUTY = 2'b10
	} th_phase_t;
endpackage

// ---- hdl/th_cnt_if.sv ----
// Count clock select and tick between the timer core and its prescaler
interface th_cnt_if;
	logic [2:0] clkSel;
	logic       tick;
	modport src (input clkSel, output tick);
	modport dst (output clkSel, input tick);
endinterface

// ---- hdl/th_prescaler.sv ----
// Count clock prescaler: one-cycle tick at the selected count rate
module th_prescaler
	import th_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Low-speed oscillator pin
	input  wire logic lowSpeedClk,
	// Timer core side
	th_cnt_if.src     cnt
);
	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic        lsPrev;
		logic [11:0] fastCnt;
		logic [8:0]  lsCnt;
		logic        tick;
	} th_pre_state_t;

	th_pre_state_t s_r;
	th_pre_state_t s_nxt;

	// True when the low bits of a count are all ones
	function automatic logic lowOnes(input logic [11:0] v, input int bits);
		logic [11:0] m;
		m = 12'((64'h1 << bits) - 64'h1);
		return (v & m) == m;
	endfunction

	// Divider and low-speed edge detection; sync1 feeds sync2 only
	always_comb
	begin
		logic lsEdge;
		lsEdge = s_r.sync2 & ~s_r.lsPrev;
		s_nxt = s_r;
		s_nxt.sync1 = lowSpeedClk;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.lsPrev = s_r.sync2;
		s_nxt.fastCnt = s_r.fastCnt + 12'h001;
		if (lsEdge)
			s_nxt.lsCnt = s_r.lsCnt + 9'h001;
		case (cnt.clkSel)
			CKS_DIV1:    s_nxt.tick = 1'b1;
			CKS_DIV4:    s_nxt.tick = lowOnes(s_r.fastCnt, BITS_DIV4);
			CKS_DIV16:   s_nxt.tick = lowOnes(s_r.fastCnt, BITS_DIV16);
			CKS_DIV64:   s_nxt.tick = lowOnes(s_r.fastCnt, BITS_DIV64);
			CKS_DIV4096: s_nxt.tick = lowOnes(s_r.fastCnt, BITS_DIV4096);
			CKS_LS128:   s_nxt.tick = lsEdge & lowOnes({3'h0, s_r.lsCnt}, BITS_LS128);
			CKS_LS512:   s_nxt.tick = lsEdge & lowOnes({3'h0, s_r.lsCnt}, BITS_LS512);
			default:     s_nxt.tick = lsEdge;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign cnt.tick = s_r.tick;
endmodule

// ---- hdl/th_timer.sv ----
// 8-bit interval / PWM timer with compare registers and port 3 pin 0 output
module th_timer
	import th_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// CPU data port
	input  wire logic [15:0] addr,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	output logic [7:0]      rdData,
	// Low-speed oscillator pin
	input  wire logic       lowSpeedClk,
	// Interrupt request
	output logic            compareMatchIrq,
	// Timer output and shared pin
	output logic            timerOutputPin,
	output logic            pin0Out,
	output logic            pin0Oe_n
);
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] period;
		logic [7:0] duty;
		logic [7:0] pend;
		logic       pendValid;
		logic [1:0] age;
		logic [7:0] carrier;
		logic [7:0] port3Dir;
		logic [7:0] port3Lat;
		logic [7:0] cnt;
		th_phase_t  phase;
		logic       level;
		logic       irq;
		logic       pinOut;
		logic [7:0] rdData;
	} th_state_t;

	th_state_t s_r;
	th_state_t s_nxt;
	th_cnt_if  cif ();

	th_prescaler u_pre (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.lowSpeedClk (lowSpeedClk),
		.cnt         (cif.src)
	);

	logic run;
	logic isPwm;
	logic defLevel;
	logic tick;
	logic dutyWr;
	assign run      = s_r.mode[RUN_BIT];
	assign isPwm    = s_r.mode[MODE_HI:MODE_LO] == MODE_PWM;
	assign defLevel = s_r.mode[LEVEL_BIT];
	assign tick     = cif.tick;
	assign dutyWr   = wrEn && addr == ADDR_DUTY;
	assign cif.clkSel = s_r.mode[CKS_HI:CKS_LO];

	// Register writes, then the counting engine
	always_comb
	begin
		s_nxt = s_r;
		if (wrEn)
		begin
			case (addr)
				ADDR_MODE:     s_nxt.mode = wrData;
				ADDR_PERIOD:   s_nxt.period = wrData;
				ADDR_CARRIER:  s_nxt.carrier = wrData & CARRIER_WMASK;
				ADDR_PORT3DIR: s_nxt.port3Dir = wrData | PORT3DIR_FIXED;
				ADDR_PORT3LAT: s_nxt.port3Lat = wrData;
				ADDR_DUTY:
				begin
					// latch running write
					// Only a stopped timer takes duty directly; the start cycle already counts as running
					if (!run)
					begin
						s_nxt.duty = wrData;
						s_nxt.pendValid = 1'b0;
					end
					else
					begin
						s_nxt.pend = wrData;
						s_nxt.pendValid = 1'b1;
						s_nxt.age = '0;
					end
				end
				default: ;
			endcase
		end
		if (!run)
		begin
			s_nxt.cnt = '0;
			s_nxt.irq = 1'b0;
			s_nxt.level = defLevel;
			s_nxt.phase = PH_STOP;
		end
		else if (s_r.phase == PH_STOP)
		begin
			// start, mask first tick in PWM
			s_nxt.phase = isPwm ? PH_MASK : PH_PER;
			// Level bit may arrive with the run bit, so settle the idle level here
			s_nxt.level = defLevel;
		end
		else if (tick)
		begin
			s_nxt.irq = 1'b0;
			if (s_r.pendValid && s_r.age != DUTY_AGE_MIN && !dutyWr)
				s_nxt.age = s_r.age + 2'h1;
			case (s_r.phase)
				PH_MASK: s_nxt.phase = PH_PER;
				PH_PER:
				begin
					if (s_r.cnt == s_r.period)
					begin
						s_nxt.cnt = '0;
						s_nxt.irq = 1'b1;
						s_nxt.level = isPwm ? ~defLevel : ~s_r.level;
						// only PWM moves to duty compare
						if (isPwm)
							s_nxt.phase = PH_DUTY;
					end
					else
						s_nxt.cnt = s_r.cnt + 8'h01;
				end
				PH_DUTY:
				begin
					s_nxt.cnt = s_r.cnt + 8'h01;
					if (s_r.cnt == s_r.duty)
					begin
						s_nxt.level = defLevel;
						s_nxt.phase = PH_PER;
						// transfer only when aged, no clash
						if (s_r.pendValid && s_r.age == DUTY_AGE_MIN && !dutyWr)
						begin
							s_nxt.duty = s_r.pend;
							s_nxt.pendValid = 1'b0;
						end
					end
				end
				default: s_nxt.phase = PH_STOP;
			endcase
		end
		// pin carries latch OR timer output
		s_nxt.pinOut = s_r.port3Lat[0] | (s_r.mode[OUTEN_BIT] & s_r.level);
		case (addr)
			ADDR_MODE:     s_nxt.rdData = s_r.mode;
			ADDR_PERIOD:   s_nxt.rdData = s_r.period;
			ADDR_DUTY:     s_nxt.rdData = s_r.pendValid ? s_r.pend : s_r.duty;
			ADDR_CARRIER:  s_nxt.rdData = s_r.carrier;
			ADDR_PORT3DIR: s_nxt.rdData = s_r.port3Dir;
			ADDR_PORT3LAT: s_nxt.rdData = s_r.port3Lat;
			default:       s_nxt.rdData = RST_ZERO;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.port3Dir <= RST_PORT3DIR;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs; a disabled output rests low
	assign rdData          = s_r.rdData;
	assign compareMatchIrq = s_r.irq;
	assign timerOutputPin  = s_r.mode[OUTEN_BIT] & s_r.level;
	assign pin0Out         = s_r.pinOut;
	assign pin0Oe_n        = s_r.port3Dir[0];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_interval_match;
		run && !isPwm && tick && s_r.phase == PH_PER && s_r.cnt == s_r.period
			|=> compareMatchIrq && s_r.cnt == 8'h00;
	endproperty
	a_interval_match: assert property (p_interval_match) else $error("interval match missed");

	property p_no_duty_interval;
		!isPwm |-> s_r.phase != PH_DUTY;
	endproperty
	a_no_duty_interval: assert property (p_no_duty_interval) else $error("duty phase in interval");

	property p_square_toggle;
		run && !isPwm && tick && s_r.phase == PH_PER && s_r.cnt == s_r.period && !$changed(s_r.mode)
			|=> s_r.level != $past(s_r.level);
	endproperty
	a_square_toggle: assert property (p_square_toggle) else $error("square wave not toggled");

	property p_stop_default;
		!run ##1 !run |-> !compareMatchIrq && s_r.level == $past(defLevel) && s_r.cnt == 8'h00;
	endproperty
	a_stop_default: assert property (p_stop_default) else $error("stop not at default");

	property p_pwm_period;
		run && isPwm && tick && s_r.phase == PH_PER && s_r.cnt == s_r.period
			|=> compareMatchIrq && s_r.level == !defLevel && s_r.phase == PH_DUTY;
	endproperty
	a_pwm_period: assert property (p_pwm_period) else $error("pwm period match wrong");

	property p_pwm_duty;
		run && isPwm && tick && s_r.phase == PH_DUTY && s_r.cnt == s_r.duty
			|=> !compareMatchIrq && s_r.level == defLevel && s_r.cnt == $past(s_r.cnt) + 8'h01;
	endproperty
	a_pwm_duty: assert property (p_pwm_duty) else $error("pwm duty match wrong");

	property p_pwm_mask;
		run && isPwm && s_r.phase == PH_STOP ##1 run
			|-> s_r.phase == PH_MASK && s_r.level == defLevel;
	endproperty
	a_pwm_mask: assert property (p_pwm_mask) else $error("first tick not masked");

	property p_duty_aged;
		run && $changed(s_r.duty) |-> $past(s_r.age) == DUTY_AGE_MIN && $past(s_r.phase) == PH_DUTY;
	endproperty
	a_duty_aged: assert property (p_duty_aged) else $error("duty moved too early");

	property p_start_count;
		run && !isPwm && s_r.phase == PH_STOP ##1 run |-> s_r.phase == PH_PER;
	endproperty
	a_start_count: assert property (p_start_count) else $error("start delayed");
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the interval / PWM timer
module tb_top
	import th_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {logic sel; logic [7:0] v;} th_exp_t;
	typedef struct {int gap; logic lvl;} th_irq_t;

	// Design ports
	logic        ref_clk;
	logic        rst;
	logic [15:0] addr;
	logic        wrEn;
	logic [7:0]  wrData;
	logic [7:0]  rdData;
	logic        lowSpeedClk;
	logic        compareMatchIrq;
	logic        timerOutputPin;
	logic        pin0Out;
	logic        pin0Oe_n;
	// Notes and watcher state
	th_exp_t     expQ[$];
	th_irq_t     irqQ[$];
	th_exp_t     e;
	th_irq_t     q;
	int          errors;
	int          cmpCount;
	int          gapCnt;
	int          expHi;
	int          gap;
	logic        pend;
	logic        hiChk;
	logic        irqPrev;
	logic        pinPrev;
	logic [31:0] rng;
	logic [7:0]  n;
	logic [7:0]  m;
	logic [7:0]  modes [4] = '{8'h81, 8'h85, 8'h91, 8'ha1};
	int          shifts [4] = '{0, 0, 2, 4};

	th_timer dut_u (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.addr            (addr),
		.wrEn            (wrEn),
		.wrData          (wrData),
		.rdData          (rdData),
		.lowSpeedClk     (lowSpeedClk),
		.compareMatchIrq (compareMatchIrq),
		.timerOutputPin  (timerOutputPin),
		.pin0Out         (pin0Out),
		.pin0Oe_n        (pin0Oe_n)
	);

	// Clock and a free-running slow oscillator pin
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) lowSpeedClk <= #1 ~lowSpeedClk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("Comparisons %0d, errors %0d", cmpCount, errors);
		if (errors == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One write strobe, released an edge later
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		addr = a;
		wrEn = 1'b1;
		wrData = d;
		@(posedge ref_clk);
		#1;
		wrEn = 1'b0;
	endtask

	// Note a read (sel 0) or a pin snapshot (sel 1) for the watcher
	task chk(input logic sel, input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		#1;
		addr = a;
		@(posedge ref_clk);
		#1;
		expQ.push_back('{sel, v});
		pend = 1'b1;
		@(negedge ref_clk);
	endtask

	task pushIrq(input int g, input logic l, input int k);
		repeat (k) irqQ.push_back('{g, l});
	endtask

	// Bounded wait until every noted interrupt has been seen
	task waitq;
		int i;
		for (i = 0; i < 4000 && irqQ.size() > 0; i++)
			@(posedge ref_clk);
		if (irqQ.size() > 0)
		begin
			errors++;
			conclude();
		end
	endtask

	// Watcher: each result is compared with the oldest note as it appears
	always @(negedge ref_clk)
	begin
		gapCnt++;
		if (compareMatchIrq === 1'b1 && irqPrev === 1'b0)
		begin
			if (irqQ.size() > 0)
			begin
				q = irqQ.pop_front();
				if (q.gap != 0)
					check(gapCnt, q.gap);
				check(timerOutputPin, q.lvl);
			end
			gapCnt = 0;
		end
		if (hiChk && timerOutputPin === 1'b0 && pinPrev === 1'b1)
			check(gapCnt, expHi);
		irqPrev = compareMatchIrq;
		pinPrev = timerOutputPin;
		if (pend)
		begin
			pend = 1'b0;
			e = expQ.pop_front();
			check(e.sel ? {4'h0, pin0Oe_n, pin0Out, compareMatchIrq, timerOutputPin} : rdData, e.v);
		end
	end

	initial
	begin
		ref_clk = 1'b0;
		rst = 1'b1;
		addr = 16'h0000;
		wrEn = 1'b0;
		wrData = 8'h00;
		lowSpeedClk = 1'b0;
		errors = 0;
		cmpCount = 0;
		gapCnt = 0;
		pend = 1'b0;
		hiChk = 1'b0;
		irqPrev = 1'b0;
		pinPrev = 1'b0;
		rng = 32'hf33fb381;
		repeat (2) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		// Reset values, fixed bits and an unmapped address
		chk(1'b1, ADDR_MODE, 8'h08);
		chk(1'b0, ADDR_PORT3DIR, RST_PORT3DIR);
		chk(1'b0, ADDR_MODE, RST_ZERO);
		wr(ADDR_PORT3DIR, 8'h00);
		wr(ADDR_CARRIER, 8'hff);
		wr(16'hff00, 8'hff);
		wr(ADDR_PORT3LAT, 8'h00);
		chk(1'b0, ADDR_PORT3DIR, PORT3DIR_FIXED);
		chk(1'b0, ADDR_CARRIER, CARRIER_WMASK);
		chk(1'b0, 16'hff00, 8'h00);
		// Idle level follows the default level bit
		wr(ADDR_MODE, 8'h03);
		chk(1'b1, ADDR_MODE, 8'h05);
		wr(ADDR_MODE, 8'h01);
		chk(1'b1, ADDR_MODE, 8'h00);
		// Interval under codes 00 and 01, at three count rates; duty is noise
		for (int i = 0; i < 4; i++)
		begin
			rng = lfsr(rng);
			n = {5'h00, rng[2:0]} + 8'h01;
			gap = (int'(n) + 1) << shifts[i];
			wr(ADDR_PERIOD, n);
			wr(ADDR_DUTY, rng[15:8]);
			chk(1'b0, ADDR_PERIOD, n);
			wr(ADDR_MODE, modes[i]);
			pushIrq(0, 1'b1, 1);
			pushIrq(gap, 1'b0, 1);
			pushIrq(gap, 1'b1, 1);
			waitq();
			wr(ADDR_MODE, modes[i] & 8'h7f);
			chk(1'b1, ADDR_MODE, 8'h00);
		end
		// PWM: masked start, active width, then a duty change while running
		rng = lfsr(rng);
		n = {4'h0, rng[3:0]} + 8'h04;
		m = rng[15:8] % n;
		wr(ADDR_PERIOD, n);
		wr(ADDR_DUTY, m);
		wr(ADDR_MODE, 8'h89);
		chk(1'b1, ADDR_MODE, 8'h00);
		expHi = int'(m) + 1;
		hiChk = 1'b1;
		pushIrq(0, 1'b1, 1);
		pushIrq(int'(n) + 1, 1'b1, 2);
		waitq();
		// Old duty holds until its own match has passed
		hiChk = 1'b0;
		m = (m == 8'h00) ? n - 8'h01 : 8'h00;
		wr(ADDR_DUTY, m);
		chk(1'b0, ADDR_DUTY, m);
		// A short period may see one old match before the value has aged and a second at its transfer
		pushIrq(int'(n) + 1, 1'b1, 3);
		waitq();
		expHi = int'(m) + 1;
		hiChk = 1'b1;
		pushIrq(int'(n) + 1, 1'b1, 2);
		waitq();
		hiChk = 1'b0;
		wr(ADDR_MODE, 8'h09);
		chk(1'b1, ADDR_MODE, 8'h00);
		conclude();
	end
endmodule
